// ==== core/base_link_checker.sv ====
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module base_link_checker
    import ph_link_pkg::*;
#(
    parameter int FLASH_CYC = FLASH_HALF_CYC,
    parameter int RELAY_CYC = RELAY_HALF_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    ph_link_if.base          link,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             irq,
    output logic             relay_wave
);

    //**************************************************************
    // state
    //**************************************************************
    logic                  rx_a, rx_b, served, clk_q, primed, blink;
    logic [DIV_W-1:0]      div_cnt;
    logic [CNT_W-1:0]      rx_cnt;
    logic [FRAME_BITS-1:0] rx_sh, frame;
    logic [CTRL_W-1:0]     ctrl;
    logic [IRQ_W-1:0]      irq_stat, irq_mask;
    logic [31:0]           flash_cnt, relay_cnt;
    logic                  next_served, next_clk_q, next_primed, next_blink, next_wave;
    logic [DIV_W-1:0]      next_div_cnt;
    logic [CNT_W-1:0]      next_rx_cnt;
    logic [FRAME_BITS-1:0] next_rx_sh, next_frame, got;
    logic [CTRL_W-1:0]     next_ctrl;
    logic [IRQ_W-1:0]      next_irq_stat, next_irq_mask, ev;
    logic [31:0]           next_readdata, next_flash_cnt, next_relay_cnt;
    logic                  fall_tick, fault, wr_go;
    lamp_mode_t            mode;

    assign waitrequest = (read | write) & ~served;
    assign wr_go       = write & served;
    assign fault       = irq_stat[IRQ_FAULT];
    assign mode        = lamp_mode_t'(ctrl[CTRL_LAMP +: 2]);
    assign fall_tick   = (div_cnt == DIV_W'(LINK_HALF_CYC - 1)) & clk_q;
    assign got         = {rx_sh[FRAME_BITS-2:0], rx_b};
    assign irq         = |(irq_stat & irq_mask);

    //**************************************************************
    // next state
    //**************************************************************
    always_comb
    begin
        next_served    = (read | write) & ~served;
        next_readdata  = readdata;
        next_div_cnt   = div_cnt + 1'b1;
        next_clk_q     = clk_q;
        next_primed    = primed;
        next_rx_cnt    = rx_cnt;
        next_rx_sh     = rx_sh;
        next_frame     = frame;
        next_ctrl      = ctrl;
        next_irq_mask  = irq_mask;
        next_flash_cnt = flash_cnt + 1'b1;
        next_blink     = blink;
        next_relay_cnt = relay_cnt + 1'b1;
        next_wave      = relay_wave;
        ev             = '0;
        if (div_cnt == DIV_W'(LINK_HALF_CYC - 1))
        begin
            next_div_cnt = '0;
            next_clk_q   = ~clk_q;
        end
        if (fall_tick)
        begin
            next_primed = 1'b1;
            if (primed)
            begin
                next_rx_sh  = got;
                next_rx_cnt = rx_cnt + 1'b1;
                if (rx_cnt == LAST_BIT)
                begin
                    next_rx_cnt = '0;
                    if (got[TRAIL_LSB +: TRAIL_W] == TRAILER)
                    begin
                        next_frame       = got;
                        ev[IRQ_FRAME]    = 1'b1;
                    end
                    else
                    begin
                        ev[IRQ_FAULT]    = 1'b1;
                    end
                end
            end
        end
        if (flash_cnt == 32'(FLASH_CYC - 1))
        begin
            next_flash_cnt = '0;
            next_blink     = ~blink;
        end
        if (relay_cnt == 32'(RELAY_CYC - 1))
        begin
            next_relay_cnt = '0;
            next_wave      = ~relay_wave;
        end
        // steady level holds the safe relay open
        if (!ctrl[CTRL_DRIVE] || fault)
        begin
            next_wave = 1'b0;
        end
        if (read && !served)
        begin
            if (address == REG_CTRL)
                next_readdata = 32'(ctrl);
            else if (address == REG_FRAME)
                next_readdata = 32'(frame);
            else if (address == REG_IRQ_STAT)
                next_readdata = 32'(irq_stat);
            else if (address == REG_IRQ_MASK)
                next_readdata = 32'(irq_mask);
            else
                next_readdata = '0;
        end
        next_irq_stat = irq_stat;
        if (wr_go && address == REG_CTRL)
            next_ctrl = writedata[CTRL_W-1:0];
        else if (wr_go && address == REG_IRQ_MASK)
            next_irq_mask = writedata[IRQ_W-1:0];
        else if (wr_go && address == REG_IRQ_STAT)
            next_irq_stat = irq_stat & ~writedata[IRQ_W-1:0];
        // a new event wins over the clear
        next_irq_stat = next_irq_stat | ev;
    end

    //**************************************************************
    // registers
    //**************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_a <= 1'b0;
            rx_b <= 1'b0;
            served <= 1'b0;
            readdata <= '0;
            div_cnt <= '0;
            clk_q <= 1'b1;
            primed <= 1'b0;
            rx_cnt <= '0;
            rx_sh <= '0;
            frame <= '0;
            ctrl <= CTRL_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            flash_cnt <= '0;
            blink <= 1'b0;
            relay_cnt <= '0;
            relay_wave <= 1'b0;
        end
        else
        begin
            rx_a <= link.data_p & ~link.data_n;
            rx_b <= rx_a;
            served <= next_served;
            readdata <= next_readdata;
            div_cnt <= next_div_cnt;
            clk_q <= next_clk_q;
            primed <= next_primed;
            rx_cnt <= next_rx_cnt;
            rx_sh <= next_rx_sh;
            frame <= next_frame;
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            flash_cnt <= next_flash_cnt;
            blink <= next_blink;
            relay_cnt <= next_relay_cnt;
            relay_wave <= next_wave;
        end
    end

    //**************************************************************
    // link outputs
    //**************************************************************
    assign link.clk_p    = clk_q;
    assign link.clk_n    = ~clk_q;
    assign link.drive_en = ctrl[CTRL_DRIVE] & ~fault;
    assign link.brake_en = ctrl[CTRL_BRAKE] & ~fault;
    assign link.lamp_pos = (mode == LAMP_ENABLED) & ~fault;
    assign link.lamp_neg = (mode == LAMP_INJECTING & ~fault)
                         | ((mode == LAMP_FLASH | fault) & blink);

endmodule
`default_nettype wire

// ==== core/ph_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ph_link_if;
    logic clk_p;
    logic clk_n;
    logic data_p;
    logic data_n;
    logic lamp_pos;
    logic lamp_neg;
    logic drive_en;
    logic brake_en;

    modport base
    (
        output clk_p, clk_n, lamp_pos, lamp_neg, drive_en, brake_en,
        input  data_p, data_n
    );
    modport head
    (
        input  clk_p, clk_n, lamp_pos, lamp_neg, drive_en, brake_en,
        output data_p, data_n
    );
endinterface
`default_nettype wire

// ==== core/ph_link_pkg.sv ====
//******************************************************************
// Overview of operation
// - status inputs loaded, shifted out as one train
// - each bit level mirrors one status input
// - base makes the shift clock for the head
// - head receives differential clock, shifts on it
// - four-bit trailer ends every frame
// - bad trailer raises fault, disables the injector
// - two encoder phase bits sent for speed, direction
// - forward and reverse load keys reported
// - fast key reported, speeds loading
// - syringe size switch bit in the frame
// - tilt bit in the frame
// - over-temperature bit sits in second register
// - both travel limit bits in the frame
// - retiming stage joins the two registers
// - one lamp line, polarity selects the lamp
// - injecting lamp solid, off, or flashing in flash mode, and flashing on fault
// - drive and brake gated by base enables
// - relay enable is a square wave, low on fault or with drive off
//******************************************************************
package ph_link_pkg;

    // timing
    localparam int REF_PERIOD_NS  = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int DIV_W          = 3;
    localparam int FLASH_HALF_NS  = 250_000_000;
    localparam int FLASH_HALF_CYC = FLASH_HALF_NS / REF_PERIOD_NS;
    localparam int RELAY_HALF_NS  = 500_000;
    localparam int RELAY_HALF_CYC = RELAY_HALF_NS / REF_PERIOD_NS;

    // frame layout, first bit sent is the msb
    localparam int              SR_W       = 8;
    localparam int              FRAME_BITS = 2 * SR_W + 1;
    localparam int              CNT_W      = 5;
    localparam logic [CNT_W-1:0] LAST_BIT  = 5'h10;
    localparam int              F_RETIME   = SR_W;
    localparam int              TRAIL_LSB  = 0;
    localparam int              TRAIL_W    = 4;
    localparam logic [3:0]      TRAILER    = 4'ha;

    // status vector index and frame position of each input
    localparam int N_STATUS    = 10;
    localparam int ST_PHASE_A  = 0;
    localparam int ST_PHASE_B  = 1;
    localparam int ST_LOAD_FWD = 2;
    localparam int ST_LOAD_REV = 3;
    localparam int ST_FAST     = 4;
    localparam int ST_SIZE     = 5;
    localparam int ST_TILT     = 6;
    localparam int ST_OVERTEMP = 7;
    localparam int ST_LIM_FWD  = 8;
    localparam int ST_LIM_REV  = 9;
    localparam int F_STATUS_HI = 16;
    localparam int F_LIM_FWD   = 7;
    localparam int F_LIM_REV   = 6;

    // head synchroniser slots beyond the status inputs
    localparam int SY_CLK       = 10;
    localparam int SY_LAMP_POS  = 11;
    localparam int SY_LAMP_NEG  = 12;
    localparam int SY_DRIVE     = 13;
    localparam int SY_BRAKE     = 14;
    localparam int SY_PWM_REQ   = 15;
    localparam int SY_BRAKE_REQ = 16;
    localparam int SYNC_W       = 17;

    // registers
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_FRAME    = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT = 4'h8;
    localparam logic [3:0]  REG_IRQ_MASK = 4'hc;
    localparam int          CTRL_DRIVE   = 0;
    localparam int          CTRL_BRAKE   = 1;
    localparam int          CTRL_LAMP    = 2;
    localparam int          CTRL_W       = 4;
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam int          IRQ_FRAME    = 0;
    localparam int          IRQ_FAULT    = 1;
    localparam int          IRQ_W        = 2;

    typedef enum logic [1:0] {LAMP_OFF, LAMP_ENABLED, LAMP_INJECTING, LAMP_FLASH} lamp_mode_t;

    // status vector to frame, trailer last
    function automatic logic [FRAME_BITS-1:0] build_frame(input logic [N_STATUS-1:0] st);
        logic [FRAME_BITS-1:0] f;
        f = '0;
        for (int i = 0; i <= ST_OVERTEMP; i++)
        begin
            f[F_STATUS_HI-i] = st[i];
        end
        f[F_LIM_FWD] = st[ST_LIM_FWD];
        f[F_LIM_REV] = st[ST_LIM_REV];
        f[TRAIL_LSB +: TRAIL_W] = TRAILER;
        return f;
    endfunction

endpackage

// ==== core/powerhead_status_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none
module powerhead_status_serializer
    import ph_link_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    ph_link_if.head   link,
    input  wire logic phase_a,
    input  wire logic phase_b,
    input  wire logic key_load_fwd,
    input  wire logic key_load_rev,
    input  wire logic key_fast,
    input  wire logic syringe_size,
    input  wire logic tilt_up,
    input  wire logic heater_overtemp,
    input  wire logic limit_fwd,
    input  wire logic limit_rev,
    input  wire logic pwm_request,
    input  wire logic brake_request,
    output logic      pwm_drive,
    output logic      brake_drive,
    output logic      lamp_enabled,
    output logic      lamp_injecting
);

    //**************************************************************
    // pin capture
    //**************************************************************
    logic [SYNC_W-1:0]   raw;
    logic [SYNC_W-1:0]   sync_a;
    logic [SYNC_W-1:0]   sync_b;
    logic [N_STATUS-1:0] status;
    logic                rx_clk;

    // differential line receiver
    assign rx_clk = link.clk_p & ~link.clk_n;

    always_comb
    begin
        raw               = '0;
        raw[ST_PHASE_A]   = phase_a;
        raw[ST_PHASE_B]   = phase_b;
        raw[ST_LOAD_FWD]  = key_load_fwd;
        raw[ST_LOAD_REV]  = key_load_rev;
        raw[ST_FAST]      = key_fast;
        raw[ST_SIZE]      = syringe_size;
        raw[ST_TILT]      = tilt_up;
        raw[ST_OVERTEMP]  = heater_overtemp;
        raw[ST_LIM_FWD]   = limit_fwd;
        raw[ST_LIM_REV]   = limit_rev;
        raw[SY_CLK]       = rx_clk;
        raw[SY_LAMP_POS]  = link.lamp_pos;
        raw[SY_LAMP_NEG]  = link.lamp_neg;
        raw[SY_DRIVE]     = link.drive_en;
        raw[SY_BRAKE]     = link.brake_en;
        raw[SY_PWM_REQ]   = pwm_request;
        raw[SY_BRAKE_REQ] = brake_request;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    // levels pass straight through, high means asserted
    assign status = sync_b[N_STATUS-1:0];

    //**************************************************************
    // link clock edge finder
    //**************************************************************
    logic clk_prev;
    logic next_clk_prev;
    logic clk_fall;

    always_comb
    begin
        next_clk_prev = sync_b[SY_CLK];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_prev <= 1'b0;
        end
        else
        begin
            clk_prev <= next_clk_prev;
        end
    end

    // data launches on the falling edge, base samples before the next
    assign clk_fall = clk_prev & ~sync_b[SY_CLK];

    //**************************************************************
    // shift chain: first register, retime stage, second register
    //**************************************************************
    logic [SR_W-1:0]       sr_first;
    logic                  retime;
    logic [SR_W-1:0]       sr_second;
    logic [CNT_W-1:0]      bit_cnt;
    logic [SR_W-1:0]       next_sr_first;
    logic                  next_retime;
    logic [SR_W-1:0]       next_sr_second;
    logic [CNT_W-1:0]      next_bit_cnt;
    logic [FRAME_BITS-1:0] snapshot;

    assign snapshot = build_frame(status);

    always_comb
    begin
        next_sr_first  = sr_first;
        next_retime    = retime;
        next_sr_second = sr_second;
        next_bit_cnt   = bit_cnt;
        if (clk_fall)
        begin
            if (bit_cnt == '0)
            begin
                // fresh snapshot at the start of every frame
                next_sr_second = snapshot[FRAME_BITS-1 -: SR_W];
                next_retime    = snapshot[F_RETIME];
                next_sr_first  = snapshot[SR_W-1:0];
            end
            else
            begin
                next_sr_second = {sr_second[SR_W-2:0], retime};
                next_retime    = sr_first[SR_W-1];
                next_sr_first  = {sr_first[SR_W-2:0], 1'b0};
            end
            if (bit_cnt == LAST_BIT)
            begin
                next_bit_cnt = '0;
            end
            else
            begin
                next_bit_cnt = bit_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sr_first  <= '0;
            retime    <= 1'b0;
            sr_second <= '0;
            bit_cnt   <= '0;
        end
        else
        begin
            sr_first  <= next_sr_first;
            retime    <= next_retime;
            sr_second <= next_sr_second;
            bit_cnt   <= next_bit_cnt;
        end
    end

    // differential line driver
    assign link.data_p = sr_second[SR_W-1];
    assign link.data_n = ~sr_second[SR_W-1];

    //**************************************************************
    // servo enable gating and lamp decode
    //**************************************************************
    logic next_pwm_drive;
    logic next_brake_drive;
    logic next_lamp_enabled;
    logic next_lamp_injecting;

    always_comb
    begin
        next_pwm_drive      = sync_b[SY_PWM_REQ] & sync_b[SY_DRIVE];
        next_brake_drive    = sync_b[SY_BRAKE_REQ] & sync_b[SY_BRAKE];
        // both polarities at once is not a valid line state
        next_lamp_enabled   = sync_b[SY_LAMP_POS] & ~sync_b[SY_LAMP_NEG];
        next_lamp_injecting = sync_b[SY_LAMP_NEG] & ~sync_b[SY_LAMP_POS];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_drive      <= 1'b0;
            brake_drive    <= 1'b0;
            lamp_enabled   <= 1'b0;
            lamp_injecting <= 1'b0;
        end
        else
        begin
            pwm_drive      <= next_pwm_drive;
            brake_drive    <= next_brake_drive;
            lamp_enabled   <= next_lamp_enabled;
            lamp_injecting <= next_lamp_injecting;
        end
    end

endmodule
`default_nettype wire

// ==== verif/ph_link_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ph_link_asserts
    import ph_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_p,
    input wire logic clk_n,
    input wire logic data_p,
    input wire logic data_n,
    input wire logic lamp_pos,
    input wire logic lamp_neg,
    input wire logic drive_en,
    input wire logic brake_en
);
    localparam logic [16:0] TRAIL_MASK = 17'h0000f;
    localparam logic [16:0] ZERO_MASK  = 17'h00130;
    localparam logic [16:0] FIX_VAL    = {13'h0000, TRAILER};

    logic       clk_d;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    wire  [4:0] idx = 5'h10 - cnt;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // falls seen so far in the current frame
    always_comb
    begin
        next_cnt = cnt;
        if (clk_d && !clk_p)
            next_cnt = (cnt == 5'h11) ? 5'h01 : cnt + 5'h01;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_d <= 1'b1;
            cnt   <= 5'h00;
        end
        else
        begin
            clk_d <= clk_p;
            cnt   <= next_cnt;
        end
    end

    property p_clk_diff; clk_n == !clk_p; endproperty
    a_clk_diff: assert property (p_clk_diff) else $error("clock pair not complementary");
    property p_data_diff; data_n == !data_p; endproperty
    a_data_diff: assert property (p_data_diff) else $error("data pair not complementary");
    property p_lamp_excl; !(lamp_pos && lamp_neg); endproperty
    a_lamp_excl: assert property (p_lamp_excl) else $error("both lamp polarities driven");
    property p_clk_high; $rose(clk_p) |=> clk_p[*3] ##1 !clk_p; endproperty
    a_clk_high: assert property (p_clk_high) else $error("link clock high phase wrong");
    property p_clk_low; $fell(clk_p) |=> !clk_p[*3] ##1 clk_p; endproperty
    a_clk_low: assert property (p_clk_low) else $error("link clock low phase wrong");
    property p_shift_edge; $fell(clk_p) |-> $stable(data_p)[*3]; endproperty
    a_shift_edge: assert property (p_shift_edge) else $error("data moved too soon after fall");
    property p_bit_hold; $changed(data_p) |=> $stable(data_p)[*6]; endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("serial bit held too short");
    property p_trailer;
        $fell(clk_p) && cnt <= 5'h10 && TRAIL_MASK[idx] |-> ##6 (data_p == FIX_VAL[$past(idx, 6)]);
    endproperty
    a_trailer: assert property (p_trailer) else $error("trailer bit wrong");
    property p_spare;
        $fell(clk_p) && cnt <= 5'h10 && ZERO_MASK[idx] |-> ##6 !data_p;
    endproperty
    a_spare: assert property (p_spare) else $error("spare or retime slot not zero");
    c_frame_end: cover property ($fell(clk_p) && cnt == 5'h10);
    c_lamp_pos: cover property ($rose(lamp_pos));
    c_lamp_neg: cover property ($rose(lamp_neg));
    c_servo: cover property ($rose(drive_en) ##[1:50] $rose(brake_en));
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ph_link_pkg::*;
;
    localparam int FLASH_C = 4;
    localparam int RELAY_C = 4;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  st = '0;
    logic        pwm_req = 1'b0;
    logic        brk_req = 1'b0;
    logic [3:0]  address [2] = '{4'h0, 4'h0};
    logic        read [2] = '{1'b0, 1'b0};
    logic        write [2] = '{1'b0, 1'b0};
    logic [31:0] writedata [2] = '{32'h0, 32'h0};
    logic [31:0] readdata [2];
    logic        waitrequest [2];
    logic        irq [2];
    logic        relay [2];
    logic        pwm_drive, brake_drive, lamp_enabled, lamp_injecting;
    logic [3:0]  pv, cv;
    logic [16:0] exp_q [$];
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          tg [4];

    ph_link_if links [2] ();
    always #25 ref_clk = ~ref_clk;
    // second base sees a head that never sends the trailer
    assign links[1].data_p = 1'b0;
    assign links[1].data_n = 1'b1;

    for (genvar b = 0; b < 2; b++)
    begin : base_gen
        base_link_checker #(.FLASH_CYC(FLASH_C), .RELAY_CYC(RELAY_C)) base_link_checker_inst (
            .ref_clk(ref_clk), .rst_n(rst_n), .link(links[b]), .address(address[b]),
            .read(read[b]), .write(write[b]), .writedata(writedata[b]), .readdata(readdata[b]),
            .waitrequest(waitrequest[b]), .irq(irq[b]), .relay_wave(relay[b]));
    end
    powerhead_status_serializer powerhead_status_serializer_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(links[0]), .phase_a(st[0]), .phase_b(st[1]),
        .key_load_fwd(st[2]), .key_load_rev(st[3]), .key_fast(st[4]), .syringe_size(st[5]),
        .tilt_up(st[6]), .heater_overtemp(st[7]), .limit_fwd(st[8]), .limit_rev(st[9]),
        .pwm_request(pwm_req), .brake_request(brk_req), .pwm_drive(pwm_drive),
        .brake_drive(brake_drive), .lamp_enabled(lamp_enabled), .lamp_injecting(lamp_injecting));
    ph_link_asserts ph_link_asserts_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_p(links[0].clk_p), .clk_n(links[0].clk_n),
        .data_p(links[0].data_p), .data_n(links[0].data_n), .lamp_pos(links[0].lamp_pos),
        .lamp_neg(links[0].lamp_neg), .drive_en(links[0].drive_en), .brake_en(links[0].brake_en));

    //******************************************************************
    // bus, model and reporting
    //******************************************************************
    function automatic logic [16:0] model_frame(input logic [9:0] s);
        return {s[0], s[1], s[2], s[3], s[4], s[5], s[6], s[7], 1'b0, s[8], s[9], 2'b00, TRAILER};
    endfunction

    task summarize;
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus(input int b, input bit wr, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge ref_clk);
        address[b] <= a;
        writedata[b] <= d;
        read[b] <= !wr;
        write[b] <= wr;
        do @(posedge ref_clk); while (waitrequest[b] !== 1'b0);
        q = readdata[b];
        read[b] <= 1'b0;
        write[b] <= 1'b0;
    endtask

    task wr(input int b, input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(b, 1'b1, a, d, q);
    endtask

    task poll(input int b, input int i, output logic [31:0] q);
        do bus(b, 1'b0, REG_IRQ_STAT, 32'h0, q); while (q[i] !== 1'b1);
    endtask

    // counts toggles of relay, head lamp, fault lamp, fault relay
    task watch(input int n);
        tg = '{0, 0, 0, 0};
        @(negedge ref_clk);
        pv = {relay[1], links[1].lamp_neg, lamp_injecting, relay[0]};
        repeat (n)
        begin
            @(negedge ref_clk);
            cv = {relay[1], links[1].lamp_neg, lamp_injecting, relay[0]};
            for (int i = 0; i < 4; i++)
                if (cv[i] !== pv[i])
                    tg[i]++;
            pv = cv;
        end
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    //******************************************************************
    // scenarios
    //******************************************************************
    initial
    begin
        logic [31:0] q, f0;
        logic [9:0]  ns;
        void'($urandom(88));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(0, 1'b0, REG_CTRL, 32'h0, q);
        check("ctrl_reset", q, {28'h0, CTRL_RESET});
        wr(0, 4'h2, 32'hffffffff);
        bus(0, 1'b0, 4'h2, 32'h0, q);
        check("unmapped", q, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            ns = (k == 0) ? 10'h000 : (k == 1) ? 10'h3ff : 10'($urandom);
            st <= ns;
            exp_q.push_back(model_frame(ns));
            repeat (300) @(posedge ref_clk);
            wr(0, REG_IRQ_MASK, 32'h1);
            wr(0, REG_IRQ_STAT, 32'h1);
            poll(0, IRQ_FRAME, q);
            @(negedge ref_clk);
            check("irq_frame", 32'(irq[0]), 32'h1);
            bus(0, 1'b0, REG_FRAME, 32'h0, q);
            check("frame", q, 32'(exp_q.pop_front()));
        end
        wr(0, REG_IRQ_MASK, 32'h0);
        f0 = q;
        wr(0, REG_FRAME, 32'h0);
        bus(0, 1'b0, REG_FRAME, 32'h0, q);
        check("frame_ro", q, f0);
        bus(0, 1'b0, REG_IRQ_STAT, 32'h0, q);
        check("no_fault", 32'(q[IRQ_FAULT]), 32'h0);
        check("irq_masked", 32'(irq[0]), 32'h0);
        for (int k = 0; k < 16; k++)
        begin
            wr(0, REG_CTRL, 32'(k[1:0]));
            {brk_req, pwm_req} <= k[3:2];
            repeat (6) @(posedge ref_clk);
            check("pwm_drive", 32'(pwm_drive), 32'(k[2] & k[0]));
            check("brake_drive", 32'(brake_drive), 32'(k[3] & k[1]));
        end
        for (int k = 0; k < 3; k++)
        begin
            wr(0, REG_CTRL, 32'(k << 2));
            repeat (6) @(posedge ref_clk);
            check("lamp_enabled", 32'(lamp_enabled), 32'(k == 1));
            check("lamp_injecting", 32'(lamp_injecting), 32'(k == 2));
        end
        wr(0, REG_CTRL, 32'hd);
        wr(1, REG_CTRL, 32'h7);
        wr(1, REG_IRQ_MASK, 32'h2);
        poll(1, IRQ_FAULT, q);
        check("fault_bit", 32'(q[IRQ_FAULT]), 32'h1);
        repeat (20) @(posedge ref_clk);
        watch(80);
        check("relay_wave", 32'(tg[0]), 32'(80 / RELAY_C));
        check("lamp_flash", 32'(tg[1]), 32'(80 / FLASH_C));
        check("fault_flash", 32'(tg[2]), 32'(80 / FLASH_C));
        check("fault_relay", 32'(tg[3]), 32'h0);
        check("fault_drive", 32'(links[1].drive_en), 32'h0);
        check("fault_brake", 32'(links[1].brake_en), 32'h0);
        check("fault_lamp", 32'(links[1].lamp_pos), 32'h0);
        check("fault_irq", 32'(irq[1]), 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
